/* File: rtl/tja_pkg.sv */
// Constants and types shared by the tributary justification adapter
package tja_pkg;
   // Aggregate frame geometry, bit interleaved over four timeslots
   localparam int LANES = 4;
   localparam int SETS = 6;
   localparam int SET_BITS = 488;
   localparam int OH_BITS = 16;
   localparam int CTRL_END = 4;
   localparam int JUST_SET = 5;
   localparam int JUST_END = 8;
   localparam int MAJ_MIN = 3;
   // Elastic stores: pointer has one wrap bit above the address
   localparam int PW = 6;
   localparam int DEPTH = 32;
   localparam logic [PW-1:0] HALF = 6'h10;
   localparam logic [PW-1:0] NEAR_FULL = 6'h1F;
   localparam logic [PW-1:0] PTR_RST = 6'h00;
   localparam logic [DEPTH-1:0] BUF_RST = 32'hFFFFFFFF;
   // Smoothed tributary clock from a phase accumulator
   localparam int CLOCK_KHZ = 50000;
   localparam int TRIB_KHZ = 34368;
   localparam int NCO_W = 24;
   localparam logic [NCO_W-1:0] NCO_RST = 24'h000000;
   localparam logic [NCO_W-1:0] NCO_INC =
      NCO_W'((64'(TRIB_KHZ) << NCO_W) / 64'(CLOCK_KHZ));
   localparam int TRIM_SHIFT = 4;
   // All-ones switch limit; the path needs three cycles, far inside it
   localparam int CLOCK_PERIOD_NS = 20;
   localparam int AIS_LIMIT_US = 50;
   localparam int AIS_LIMIT_CYC = AIS_LIMIT_US * 1000 / CLOCK_PERIOD_NS;
   localparam logic [2:0] SET_RST = 3'h0;
   localparam logic [8:0] OFF_RST = 9'h000;

   typedef enum logic [1:0] {
      TJA_K_NONE = 2'b00,
      TJA_K_DATA = 2'b01,
      TJA_K_CTRL = 2'b10,
      TJA_K_JUST = 2'b11
   } tja_kind_e;

   typedef enum logic {
      TJA_RD_FILL = 1'b0,
      TJA_RD_RUN = 1'b1
   } tja_rd_e;
endpackage

/* File: rtl/tja_adapter.sv */
// Tributary justification adapter: demapper and mapper for one timeslot
`timescale 1ns/1ps
module tja_adapter #(
   parameter int TIMESLOT = 1
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic AGG_CLK,
   input wire logic AGG_IN_DATA,
   input wire logic AGG_IN_FS,
   input wire logic TRAIL_FAIL_IN,
   input wire logic DEMAP_ACTIVATION_CONTROL,
   output logic TRIB_OUT_DATA,
   output logic TRIB_OUT_STB,
   output logic SERVER_FAIL_OUT,
   output logic INSERT_ALL_ONES_ACTION,
   output logic BUFFER_SLIP_DEFECT,
   input wire logic TRIB_IN_CLK,
   input wire logic TRIB_IN_DATA,
   input wire logic AGG_TI_FS,
   input wire logic MAP_ACTIVATION_CONTROL,
   output logic AGG_OUT_DATA,
   output logic AGG_OUT_EN
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   localparam logic [1:0] LANE = 2'(TIMESLOT - 1);

   function automatic tja_pkg::tja_kind_e slot_kind(input logic [2:0] set,
                                                    input logic [8:0] off);
      tja_pkg::tja_kind_e k;
      k = tja_pkg::TJA_K_NONE;
      if (off[1:0] == LANE) begin
         if (set == 3'h0) begin
            if (off >= 9'(tja_pkg::OH_BITS)) begin
               k = tja_pkg::TJA_K_DATA;
            end
         end else if (off < 9'(tja_pkg::CTRL_END)) begin
            k = tja_pkg::TJA_K_CTRL;
         end else if (set == 3'(tja_pkg::JUST_SET) && off < 9'(tja_pkg::JUST_END)) begin
            k = tja_pkg::TJA_K_JUST;
         end else begin
            k = tja_pkg::TJA_K_DATA;
         end
      end
      return k;
   endfunction

   function automatic logic [tja_pkg::PW-1:0] bin2gray(input logic [tja_pkg::PW-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [tja_pkg::PW-1:0] gray2bin(input logic [tja_pkg::PW-1:0] g);
      logic [tja_pkg::PW-1:0] b;
      b = g;
      for (int i = tja_pkg::PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // Next frame position, wrapping set and offset
   function automatic logic [11:0] pos_step(input logic [2:0] set, input logic [8:0] off);
      logic [2:0] s;
      logic [8:0] o;
      s = set;
      o = off + 9'h001;
      if (o == 9'(tja_pkg::SET_BITS)) begin
         o = 9'h000;
         s = (set == 3'(tja_pkg::SETS - 1)) ? 3'h0 : set + 3'h1;
      end
      return {s, o};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State of both domains

   typedef struct packed {
      logic tf1;
      logic tf2;
      logic [tja_pkg::PW-1:0] dw1;
      logic [tja_pkg::PW-1:0] dw2;
      logic [tja_pkg::PW-1:0] drp;
      tja_pkg::tja_rd_e rd;
      logic [tja_pkg::NCO_W-1:0] acc;
      logic odata;
      logic ostb;
      logic all_ones_alarm;
      logic ssf;
      logic slip;
      logic tc1;
      logic tc2;
      logic tc3;
      logic td1;
      logic td2;
      logic [tja_pkg::PW-1:0] mwp;
      logic [tja_pkg::PW-1:0] mwg;
      logic [tja_pkg::DEPTH-1:0] mbuf;
   } tja_sys_s;

   typedef struct packed {
      logic rs1;
      logic rs2;
      logic ma1;
      logic ma2;
      logic [2:0] dset;
      logic [8:0] doff;
      logic [2:0] cones;
      logic [tja_pkg::PW-1:0] dwp;
      logic [tja_pkg::PW-1:0] dwg;
      logic [tja_pkg::DEPTH-1:0] dbuf;
      logic [2:0] mset;
      logic [8:0] moff;
      logic mstuff;
      logic [tja_pkg::PW-1:0] mrp;
      logic [tja_pkg::PW-1:0] mw1;
      logic [tja_pkg::PW-1:0] mw2;
      logic odata;
      logic oen;
   } tja_link_s;

   tja_sys_s sys_reg;
   tja_sys_s sys_next;
   tja_link_s lnk_reg;
   tja_link_s lnk_next;

   ////////////////////////////////////////////////////////////////////////////
   // System clock domain: smoothed demap read, mapper store write

   logic [tja_pkg::PW-1:0] d_wbin;
   logic [tja_pkg::PW-1:0] d_fill;
   logic [tja_pkg::NCO_W-1:0] d_inc;
   logic [tja_pkg::NCO_W:0] d_sum;
   logic d_tick;
   logic d_ones;

   always_comb begin
      d_wbin = gray2bin(sys_reg.dw2);
      d_fill = d_wbin - sys_reg.drp;
      // Fill error trims the rate so the read clock follows the far end
      d_inc = tja_pkg::NCO_INC
         + (tja_pkg::NCO_W'($signed(d_fill - tja_pkg::HALF)) <<< tja_pkg::TRIM_SHIFT);
      d_sum = {1'b0, sys_reg.acc} + {1'b0, d_inc};
      d_tick = d_sum[tja_pkg::NCO_W];
      d_ones = !DEMAP_ACTIVATION_CONTROL || sys_reg.tf2;
      sys_next = sys_reg;
      if (!RST_N) begin
         sys_next.tf1 = 1'b0;
         sys_next.tf2 = 1'b0;
         sys_next.dw1 = tja_pkg::PTR_RST;
         sys_next.dw2 = tja_pkg::PTR_RST;
         sys_next.drp = tja_pkg::PTR_RST;
         sys_next.rd = tja_pkg::TJA_RD_FILL;
         sys_next.acc = tja_pkg::NCO_RST;
         sys_next.odata = 1'b1;
         sys_next.ostb = 1'b0;
         sys_next.all_ones_alarm = 1'b0;
         sys_next.ssf = 1'b0;
         sys_next.slip = 1'b0;
         sys_next.tc1 = 1'b0;
         sys_next.tc2 = 1'b0;
         sys_next.tc3 = 1'b0;
         sys_next.td1 = 1'b0;
         sys_next.td2 = 1'b0;
         sys_next.mwp = tja_pkg::PTR_RST;
         sys_next.mwg = tja_pkg::PTR_RST;
         sys_next.mbuf = tja_pkg::BUF_RST;
      end else if (CE) begin
         // Crossings from the link domain, the trail fail input and the tributary pins
         sys_next.tf1 = TRAIL_FAIL_IN;
         sys_next.tf2 = sys_reg.tf1;
         sys_next.dw1 = lnk_reg.dwg;
         sys_next.dw2 = sys_reg.dw1;
         sys_next.tc1 = TRIB_IN_CLK;
         sys_next.tc2 = sys_reg.tc1;
         sys_next.tc3 = sys_reg.tc2;
         sys_next.td1 = TRIB_IN_DATA;
         sys_next.td2 = sys_reg.td1;
         sys_next.all_ones_alarm = sys_reg.tf2;
         sys_next.ssf = sys_reg.tf2;
         // Evenly spaced strobe runs even while ones are substituted
         sys_next.acc = d_sum[tja_pkg::NCO_W-1:0];
         sys_next.ostb = d_tick;
         if (d_tick) begin
            sys_next.odata = 1'b1;
            sys_next.slip = 1'b0;
            case (sys_reg.rd)
               tja_pkg::TJA_RD_FILL: begin
                  // Start reading only once the store is centred
                  if (d_fill >= tja_pkg::HALF) begin
                     sys_next.rd = tja_pkg::TJA_RD_RUN;
                  end
               end
               tja_pkg::TJA_RD_RUN: begin
                  if (d_fill == tja_pkg::PTR_RST) begin
                     sys_next.slip = 1'b1;
                     sys_next.rd = tja_pkg::TJA_RD_FILL;
                  end else if (d_fill >= tja_pkg::NEAR_FULL) begin
                     // Overrun: jump back to centre, losing bits once
                     sys_next.slip = 1'b1;
                     sys_next.drp = d_wbin - tja_pkg::HALF;
                  end else begin
                     sys_next.odata = lnk_reg.dbuf[sys_reg.drp[tja_pkg::PW-2:0]];
                     sys_next.drp = sys_reg.drp + 6'h01;
                  end
               end
               default: begin
                  sys_next.rd = tja_pkg::TJA_RD_FILL;
               end
            endcase
            if (d_ones) begin
               sys_next.odata = 1'b1;
            end
         end
         // Slip flag held clear while inactive, so no slip status leaks out
         if (!DEMAP_ACTIVATION_CONTROL) begin
            sys_next.slip = 1'b0;
         end
         // Mapper write on each rising tributary clock edge
         if (sys_reg.tc2 && !sys_reg.tc3) begin
            sys_next.mbuf[sys_reg.mwp[tja_pkg::PW-2:0]] = sys_reg.td2;
            sys_next.mwp = sys_reg.mwp + 6'h01;
            sys_next.mwg = bin2gray(sys_reg.mwp + 6'h01);
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      sys_reg <= sys_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link clock domain: demap write, mapper read and frame insertion

   tja_pkg::tja_kind_e dk;
   tja_pkg::tja_kind_e mk;
   logic [2:0] dset_c;
   logic [8:0] doff_c;
   logic [2:0] mset_c;
   logic [8:0] moff_c;
   logic [tja_pkg::PW-1:0] m_fill;
   logic m_stuff_c;
   logic m_bit;
   logic [11:0] dpos_n;
   logic [11:0] mpos_n;

   always_comb begin
      dset_c = AGG_IN_FS ? tja_pkg::SET_RST : lnk_reg.dset;
      doff_c = AGG_IN_FS ? tja_pkg::OFF_RST : lnk_reg.doff;
      mset_c = AGG_TI_FS ? tja_pkg::SET_RST : lnk_reg.mset;
      moff_c = AGG_TI_FS ? tja_pkg::OFF_RST : lnk_reg.moff;
      dk = slot_kind(dset_c, doff_c);
      mk = slot_kind(mset_c, moff_c);
      dpos_n = pos_step(dset_c, doff_c);
      mpos_n = pos_step(mset_c, moff_c);
      m_fill = gray2bin(lnk_reg.mw2) - lnk_reg.mrp;
      // Positive justification when the store runs low
      m_stuff_c = (mset_c == 3'h0 && moff_c == 9'h000)
         ? (m_fill < tja_pkg::HALF) : lnk_reg.mstuff;
      m_bit = sys_reg.mbuf[lnk_reg.mrp[tja_pkg::PW-2:0]];
      lnk_next = lnk_reg;
      lnk_next.rs1 = RST_N;
      lnk_next.rs2 = lnk_reg.rs1;
      lnk_next.ma1 = MAP_ACTIVATION_CONTROL;
      lnk_next.ma2 = lnk_reg.ma1;
      lnk_next.mw1 = sys_reg.mwg;
      lnk_next.mw2 = lnk_reg.mw1;
      if (!lnk_reg.rs2) begin
         lnk_next.dset = tja_pkg::SET_RST;
         lnk_next.doff = tja_pkg::OFF_RST;
         lnk_next.cones = 3'h0;
         lnk_next.dwp = tja_pkg::PTR_RST;
         lnk_next.dwg = tja_pkg::PTR_RST;
         lnk_next.dbuf = tja_pkg::BUF_RST;
         lnk_next.mset = tja_pkg::SET_RST;
         lnk_next.moff = tja_pkg::OFF_RST;
         lnk_next.mstuff = 1'b0;
         lnk_next.mrp = tja_pkg::PTR_RST;
         lnk_next.odata = 1'b0;
         lnk_next.oen = 1'b0;
      end else begin
         // Demapper: count control ones, then judge the opportunity bit
         lnk_next.dset = dpos_n[11:9];
         lnk_next.doff = dpos_n[8:0];
         if (dset_c == 3'h0 && doff_c == 9'h000) begin
            lnk_next.cones = 3'h0;
         end
         case (dk)
            tja_pkg::TJA_K_CTRL: begin
               lnk_next.cones = lnk_reg.cones + {2'b00, AGG_IN_DATA};
            end
            tja_pkg::TJA_K_DATA, tja_pkg::TJA_K_JUST: begin
               // Opportunity bit kept only on a zero majority
               if (dk == tja_pkg::TJA_K_DATA
                   || lnk_reg.cones < 3'(tja_pkg::MAJ_MIN)) begin
                  lnk_next.dbuf[lnk_reg.dwp[tja_pkg::PW-2:0]] = AGG_IN_DATA;
                  lnk_next.dwp = lnk_reg.dwp + 6'h01;
                  lnk_next.dwg = bin2gray(lnk_reg.dwp + 6'h01);
               end
            end
            default: begin
            end
         endcase
         // Mapper: insert data, control group and opportunity bit
         lnk_next.mset = mpos_n[11:9];
         lnk_next.moff = mpos_n[8:0];
         lnk_next.mstuff = m_stuff_c;
         lnk_next.oen = lnk_reg.ma2 && mk != tja_pkg::TJA_K_NONE;
         lnk_next.odata = 1'b1;
         case (mk)
            tja_pkg::TJA_K_CTRL: begin
               lnk_next.odata = m_stuff_c;
            end
            tja_pkg::TJA_K_DATA, tja_pkg::TJA_K_JUST: begin
               if ((mk == tja_pkg::TJA_K_DATA || !m_stuff_c)
                   && m_fill != tja_pkg::PTR_RST) begin
                  lnk_next.odata = m_bit;
                  lnk_next.mrp = lnk_reg.mrp + 6'h01;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge AGG_CLK) begin
      lnk_reg <= lnk_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign TRIB_OUT_DATA = sys_reg.odata;
   assign TRIB_OUT_STB = sys_reg.ostb;
   assign INSERT_ALL_ONES_ACTION = sys_reg.all_ones_alarm;
   assign SERVER_FAIL_OUT = sys_reg.ssf;
   assign BUFFER_SLIP_DEFECT = sys_reg.slip;
   assign AGG_OUT_DATA = lnk_reg.odata;
   assign AGG_OUT_EN = lnk_reg.oen;

endmodule

/* File: dv/tja_adapter_monitor.sv */
// Concurrent checks on the tributary justification adapter ports
`timescale 1ns/1ps
module tja_adapter_monitor #(
   parameter int TIMESLOT = 1
) (
   input logic CLOCK,
   input logic RST_N,
   input logic AGG_CLK,
   input logic TRAIL_FAIL_IN,
   input logic DEMAP_ACTIVATION_CONTROL,
   input logic TRIB_OUT_DATA,
   input logic TRIB_OUT_STB,
   input logic SERVER_FAIL_OUT,
   input logic INSERT_ALL_ONES_ACTION,
   input logic BUFFER_SLIP_DEFECT,
   input logic AGG_TI_FS,
   input logic MAP_ACTIVATION_CONTROL,
   input logic AGG_OUT_DATA,
   input logic AGG_OUT_EN
);
   localparam int LANE = TIMESLOT - 1;
   logic [11:0] pos_reg;
   logic seen_reg;
   logic ctrl_reg;
   logic ctrl_ok_reg;
   ////////////////////////////////////////
   // Position of the bit now at the mapper output, one bit behind framing
   always_ff @(posedge AGG_CLK) begin
      if (!RST_N) begin
         pos_reg <= 12'h000;
         seen_reg <= 1'b0;
         ctrl_ok_reg <= 1'b0;
      end else begin
         pos_reg <= AGG_TI_FS ? 12'h000 : pos_reg + 12'h001;
         seen_reg <= seen_reg | AGG_TI_FS;
         ctrl_ok_reg <= !AGG_TI_FS && (ctrl_ok_reg || (AGG_OUT_EN && pos_reg == 12'(488 + LANE)));
      end
      if (AGG_OUT_EN && pos_reg == 12'(488 + LANE)) begin
         ctrl_reg <= AGG_OUT_DATA;
      end
   end
   ////////////////////////////////////////
   // Trail fail crosses two sync flops and the output flop, so four samples cover the full latency
   a_ais_rises: assert property (@(posedge CLOCK) disable iff (!RST_N)
      TRAIL_FAIL_IN [*4] |-> INSERT_ALL_ONES_ACTION) else $error("all-ones action late");
   a_ais_falls: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (!TRAIL_FAIL_IN) [*4] |-> !INSERT_ALL_ONES_ACTION) else $error("all-ones action stuck");
   a_fail_pair: assert property (@(posedge CLOCK) disable iff (!RST_N)
      SERVER_FAIL_OUT == INSERT_ALL_ONES_ACTION) else $error("server fail differs");
   a_fail_ones: assert property (@(posedge CLOCK) disable iff (!RST_N)
      TRAIL_FAIL_IN [*4] ##0 TRIB_OUT_STB |-> TRIB_OUT_DATA) else $error("data during fail");
   a_idle_ones: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (!DEMAP_ACTIVATION_CONTROL) [*2] ##0 TRIB_OUT_STB |-> TRIB_OUT_DATA) else $error("idle data");
   a_idle_quiet: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (!DEMAP_ACTIVATION_CONTROL) [*2] |-> !BUFFER_SLIP_DEFECT) else $error("idle slip report");
   a_map_off: assert property (@(posedge AGG_CLK) disable iff (!RST_N)
      (!MAP_ACTIVATION_CONTROL) [*4] |-> !AGG_OUT_EN) else $error("idle mapper drives");
   a_map_lane: assert property (@(posedge AGG_CLK) disable iff (!RST_N)
      seen_reg && AGG_OUT_EN |-> pos_reg % 4 == LANE && pos_reg >= 16) else $error("wrong slot");
   a_ctrl_on: assert property (@(posedge AGG_CLK) disable iff (!RST_N)
      MAP_ACTIVATION_CONTROL [*4] ##0 (seen_reg && pos_reg == 12'(488 + LANE)) |-> AGG_OUT_EN)
      else $error("control bit not sent");
   a_ctrl_group: assert property (@(posedge AGG_CLK) disable iff (!RST_N)
      ctrl_ok_reg && AGG_OUT_EN && pos_reg % 488 == LANE |-> AGG_OUT_DATA == ctrl_reg)
      else $error("control bits disagree");
endmodule
bind tja_adapter tja_adapter_monitor #(.TIMESLOT(TIMESLOT)) tja_adapter_monitor_i (
   .CLOCK, .RST_N, .AGG_CLK, .TRAIL_FAIL_IN, .DEMAP_ACTIVATION_CONTROL, .TRIB_OUT_DATA,
   .TRIB_OUT_STB, .SERVER_FAIL_OUT, .INSERT_ALL_ONES_ACTION, .BUFFER_SLIP_DEFECT, .AGG_TI_FS,
   .MAP_ACTIVATION_CONTROL, .AGG_OUT_DATA, .AGG_OUT_EN);

/* File: dv/tja_far_end.sv */
// Far-end model: aggregate framing with loopback, and tributary source
`timescale 1ns/1ps
module tja_far_end (
   input wire logic agg_clk,
   input wire logic rst_n,
   input wire logic map_data,
   input wire logic map_en,
   output logic agg_data,
   output logic agg_fs,
   output logic ti_fs,
   output logic trib_clk,
   output logic trib_data
);
   logic [11:0] pos_reg = 12'h000;
   logic fill_reg = 1'b0;
   logic bit_reg = 1'b0;
   // Foreign lanes toggle every bit so a stale level never looks valid
   assign agg_data = (map_en === 1'b1) ? map_data : fill_reg;
   assign trib_data = bit_reg;
   // Tributary bits alternate, changing away from the sampling edge
   always @(negedge trib_clk) begin
      bit_reg <= ~bit_reg;
   end
   always @(posedge agg_clk) begin
      pos_reg <= !rst_n ? 12'hB54 : (pos_reg == 12'hB6F ? 12'h000 : pos_reg + 12'h001);
      ti_fs <= rst_n && pos_reg == 12'hB6F;
      agg_fs <= ti_fs; // Mapper output lags its position by one bit
      fill_reg <= ~fill_reg;
   end
   // Slower than the slot capacity, so justification is exercised
   initial begin
      trib_clk = 1'b0;
      forever #65 trib_clk = ~trib_clk;
   end
endmodule

/* File: dv/tja_adapter_tb.sv */
// Self-checking bench for the tributary justification adapter
`timescale 1ns/1ps
module tja_adapter_tb;
   localparam int SLOT = 3;
   logic CLOCK = 1'b0;
   logic AGG_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic CE = 1'b1;
   logic TRAIL_FAIL_IN = 1'b0;
   logic DEMAP_ACTIVATION_CONTROL = 1'b1;
   logic MAP_ACTIVATION_CONTROL = 1'b1;
   logic AGG_IN_DATA, AGG_IN_FS, AGG_TI_FS, TRIB_IN_CLK, TRIB_IN_DATA;
   logic TRIB_OUT_DATA, TRIB_OUT_STB, SERVER_FAIL_OUT, INSERT_ALL_ONES_ACTION;
   logic BUFFER_SLIP_DEFECT, AGG_OUT_DATA, AGG_OUT_EN;
   int err_count = 0;
   int tests_run = 0;
   int zeros;
   int slips;
   int flips;
   int en_acc = 0;
   int en_last = 0;
   ////////////////////////////////////////
   always #10 CLOCK = ~CLOCK;
   initial begin
      #7;
      forever #15 AGG_CLK = ~AGG_CLK;
   end
   // Own-slot bits driven over each whole frame
   always @(posedge AGG_CLK) begin
      if (AGG_IN_FS === 1'b1) begin
         en_last = en_acc;
         en_acc = 0;
      end
      en_acc = en_acc + int'(AGG_OUT_EN === 1'b1);
   end
   tja_adapter #(.TIMESLOT(SLOT)) tja_adapter_i (
      .CLOCK, .RST_N, .CE, .AGG_CLK, .AGG_IN_DATA, .AGG_IN_FS, .TRAIL_FAIL_IN,
      .DEMAP_ACTIVATION_CONTROL, .TRIB_OUT_DATA, .TRIB_OUT_STB, .SERVER_FAIL_OUT,
      .INSERT_ALL_ONES_ACTION, .BUFFER_SLIP_DEFECT, .TRIB_IN_CLK, .TRIB_IN_DATA,
      .AGG_TI_FS, .MAP_ACTIVATION_CONTROL, .AGG_OUT_DATA, .AGG_OUT_EN);
   tja_far_end tja_far_end_i (
      .agg_clk(AGG_CLK), .rst_n(RST_N), .map_data(AGG_OUT_DATA), .map_en(AGG_OUT_EN),
      .agg_data(AGG_IN_DATA), .agg_fs(AGG_IN_FS), .ti_fs(AGG_TI_FS),
      .trib_clk(TRIB_IN_CLK), .trib_data(TRIB_IN_DATA));
   ////////////////////////////////////////
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobed zeros and slip cycles over n clocks
   task automatic watch(input int n);
      logic stb_last;
      zeros = 0;
      slips = 0;
      flips = 0;
      stb_last = TRIB_OUT_STB;
      repeat (n) begin
         @(posedge CLOCK);
         #1;
         zeros += int'(TRIB_OUT_STB === 1'b1 && TRIB_OUT_DATA === 1'b0);
         slips += int'(BUFFER_SLIP_DEFECT === 1'b1);
         flips += int'(TRIB_OUT_STB !== stb_last);
         stb_last = TRIB_OUT_STB;
      end
   endtask
   task automatic final_report();
      if (err_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(negedge CLOCK);
      check(12'({TRIB_OUT_DATA, TRIB_OUT_STB, BUFFER_SLIP_DEFECT, AGG_OUT_EN}), 12'h008);
      RST_N = 1'b1;
      watch(14000);
      check(12'(en_last), 12'h2D8);
      check(12'(zeros != 0), 12'h001);
      // Exact sync latency of the fail input
      @(negedge CLOCK);
      TRAIL_FAIL_IN = 1'b1;
      repeat (2) @(posedge CLOCK);
      #1;
      check(12'(INSERT_ALL_ONES_ACTION), 12'h000);
      @(posedge CLOCK);
      #1;
      check(12'({INSERT_ALL_ONES_ACTION, SERVER_FAIL_OUT}), 12'h003);
      watch(3000);
      check(12'(zeros), 12'h000);
      @(negedge CLOCK);
      TRAIL_FAIL_IN = 1'b0;
      watch(2500);
      check(12'({INSERT_ALL_ONES_ACTION, zeros != 0}), 12'h001);
      // Idle demapper during a fail: actions still follow, no data, no slip
      @(negedge CLOCK);
      DEMAP_ACTIVATION_CONTROL = 1'b0;
      TRAIL_FAIL_IN = 1'b1;
      watch(3000);
      check(12'({INSERT_ALL_ONES_ACTION, zeros != 0, slips != 0}), 12'h004);
      @(negedge CLOCK);
      DEMAP_ACTIVATION_CONTROL = 1'b1;
      TRAIL_FAIL_IN = 1'b0;
      watch(3000);
      check(12'(zeros != 0), 12'h001);
      // Clock enable low freezes the system side, strobe included
      @(negedge CLOCK);
      CE = 1'b0;
      watch(100);
      check(12'(flips), 12'h000);
      @(negedge CLOCK);
      CE = 1'b1;
      watch(100);
      check(12'(flips != 0), 12'h001);
      @(negedge CLOCK);
      MAP_ACTIVATION_CONTROL = 1'b0;
      watch(9000);
      check(12'(en_last), 12'h000);
      @(negedge CLOCK);
      MAP_ACTIVATION_CONTROL = 1'b1;
      watch(9000);
      check(12'(en_last), 12'h2D8);
      final_report();
   end
   initial begin
      #1200000;
      err_count++;
      final_report();
   end
endmodule
